/* hdl/sbw_pkg.sv */
// Package for the byte-lane write decode block of a pipelined burst SRAM.
// Assumes one clock domain; shared by the core and its lane memory.
package sbw_pkg;

  // ---------------------------------------------------------------------
  // Lane layout
  // ---------------------------------------------------------------------
  localparam int LANE_DATA_W   = 8;
  localparam int LANE_PAR_POS  = 8;
  localparam int LANE_W        = 9;
  localparam int LANES_NARROW  = 2;
  localparam int LANES_WIDE    = 4;
  localparam int LANES_WIDEST  = 8;
  localparam int ADDR_W_DFLT   = 21;

  // ---------------------------------------------------------------------
  // Burst and input filtering
  // ---------------------------------------------------------------------
  localparam int BURST_BITS    = 2;
  localparam int SYNC_STAGES   = 3;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic RST_OE_ACTIVE = 1'h0;
  localparam logic RST_RD_VALID  = 1'h0;

  // ---------------------------------------------------------------------
  // Cycle kinds held in the pipeline stage
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    SBW_OP_IDLE  = 2'b00,
    SBW_OP_READ  = 2'b01,
    SBW_OP_WRITE = 2'b10
  } sbw_op_type;

endpackage

/* hdl/sbw_mem_if.sv */
// Interface between the decode core and the lane memory.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface sbw_mem_if #(
  parameter int LANES  = sbw_pkg::LANES_WIDE,
  parameter int ADDR_W = sbw_pkg::ADDR_W_DFLT
);
  logic [LANES-1:0]                 lane_we;
  logic                             rd_en;
  logic [ADDR_W-1:0]                addr;
  logic [LANES*sbw_pkg::LANE_W-1:0] wdata;
  logic [LANES*sbw_pkg::LANE_W-1:0] rdata;

  modport ctrl (output lane_we, output rd_en, output addr, output wdata, input rdata);
  modport mem  (input lane_we, input rd_en, input addr, input wdata, output rdata);
endinterface

/* hdl/sbw_lane_mem.sv */
// Lane-writable storage array, one write enable per nine-bit lane.
// Assumes a single clock; read data come out of a register.
`timescale 1ns/1ps
module sbw_lane_mem #(
  parameter int LANES  = sbw_pkg::LANES_WIDE,
  parameter int ADDR_W = sbw_pkg::ADDR_W_DFLT
) (
  input  wire logic core_clk,
  sbw_mem_if.mem    mif
);
  import sbw_pkg::*;

  logic [LANES*LANE_W-1:0] store [0:(2**ADDR_W)-1];
  logic [LANES*LANE_W-1:0] rdata_ff;

  // ---------------------------------------------------------------------
  // Array access
  // ---------------------------------------------------------------------
  // No reset on the array: contents are undefined until written
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (mif.lane_we[i])
        store[mif.addr][i*LANE_W +: LANE_W] <= mif.wdata[i*LANE_W +: LANE_W];
    end
    if (mif.rd_en)
      rdata_ff <= store[mif.addr];
  end

  assign mif.rdata = rdata_ff;

endmodule

/* hdl/sbw_sram_core.sv */
// Read/write and byte-lane write decode core of a pipelined burst SRAM.
// Assumes a memory controller on core_clk; the output enable pin is asynchronous.
//
// Functional notes
// R1: A high write strobe at a cycle start makes a read and every lane select is ignored.
// R2: A low write strobe with all lane selects high runs a write that changes no byte.
// R3: With the write strobe low, each low lane select writes that lane's byte and parity bit.
// R4: Any mix of lane selects is accepted and exactly the selected lanes are written.
// R5: During any detected write the data and parity pins stay undriven.
// R6: The controller stores data by a low write strobe, at least one low lane select and chip enabled.
// R7: The controller repeats the intended lane selects in every beat of a burst write.
// R8: The asynchronous output enable is masked internally during write cycles.
// R9: A lane is eight data bits plus one parity bit, with two, four or eight lanes per variant.
`timescale 1ns/1ps
module sbw_sram_core #(
  parameter int LANES  = sbw_pkg::LANES_WIDE,
  parameter int ADDR_W = sbw_pkg::ADDR_W_DFLT
) (
  input  wire logic                                   core_clk,
  input  wire logic                                   rstn,
  input  wire logic                                   chip_en_n,
  input  wire logic                                   advance_or_load,
  input  wire logic                                   write_strobe_n,
  input  wire logic [LANES-1:0]                       lane_write_select_n,
  input  wire logic [ADDR_W-1:0]                      addr,
  input  wire logic [LANES*sbw_pkg::LANE_DATA_W-1:0]  dq_in,
  input  wire logic [LANES-1:0]                       lane_parity_bits_in,
  input  wire logic                                   output_enable_n,
  output logic      [LANES*sbw_pkg::LANE_DATA_W-1:0]  dq_out,
  output logic      [LANES-1:0]                       lane_parity_bits_out,
  output logic                                        dq_oe
);
  import sbw_pkg::*;

  // ---------------------------------------------------------------------
  // Lane packing
  // ---------------------------------------------------------------------
  function automatic logic [LANES*LANE_W-1:0] pack_lanes(
    input logic [LANES*LANE_DATA_W-1:0] data,
    input logic [LANES-1:0]             par
  );
    logic [LANES*LANE_W-1:0] word;
    word = '0;
    for (int i = 0; i < LANES; i++)
    begin
      word[i*LANE_W +: LANE_DATA_W] = data[i*LANE_DATA_W +: LANE_DATA_W];
      word[i*LANE_W + LANE_PAR_POS] = par[i];
    end
    return word;
  endfunction

  sbw_mem_if #(.LANES(LANES), .ADDR_W(ADDR_W)) mif ();

  sbw_lane_mem #(
    .LANES  (LANES),
    .ADDR_W (ADDR_W)
  ) u_mem (
    .core_clk (core_clk),
    .mif      (mif)
  );

  // ---------------------------------------------------------------------
  // Command stage
  // ---------------------------------------------------------------------
  sbw_op_type        op_ff;
  sbw_op_type        nxt_op;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic [LANES-1:0]  sel_ff;
  logic [LANES-1:0]  nxt_sel;
  logic              rd_valid_ff;
  logic              nxt_rd_valid;

  always_comb
  begin
    nxt_op       = op_ff;
    nxt_addr     = addr_ff;
    nxt_sel      = '0;
    nxt_rd_valid = (op_ff == SBW_OP_READ);
    if (!advance_or_load)
    begin
      nxt_addr = addr;
      if (chip_en_n)
        nxt_op = SBW_OP_IDLE;
      else if (write_strobe_n)
        nxt_op = SBW_OP_READ;                    // see R1
      else
        nxt_op = SBW_OP_WRITE;
    end
    else if (op_ff != SBW_OP_IDLE)
    begin
      // Burst beat: enables and strobe are not looked at, only the counter moves
      nxt_addr[BURST_BITS-1:0] = addr_ff[BURST_BITS-1:0] + BURST_BITS'(1);
    end
    // Selects are taken fresh on every beat and only when writing
    if (nxt_op == SBW_OP_WRITE)
      nxt_sel = ~lane_write_select_n;            // see R2 see R3 see R4 see R7
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      op_ff       <= SBW_OP_IDLE;
      addr_ff     <= '0;
      sel_ff      <= '0;
      rd_valid_ff <= RST_RD_VALID;
    end
    else
    begin
      op_ff       <= nxt_op;
      addr_ff     <= nxt_addr;
      sel_ff      <= nxt_sel;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  // ---------------------------------------------------------------------
  // Data stage
  // ---------------------------------------------------------------------
  // Write data arrive in the cycle after the command
  always_comb
  begin
    mif.addr    = addr_ff;
    mif.rd_en   = (op_ff == SBW_OP_READ);
    mif.lane_we = (op_ff == SBW_OP_WRITE) ? sel_ff : '0;       // see R3 see R4
    mif.wdata   = pack_lanes(dq_in, lane_parity_bits_in);      // see R9
  end

  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      dq_out[i*LANE_DATA_W +: LANE_DATA_W] = mif.rdata[i*LANE_W +: LANE_DATA_W];
      lane_parity_bits_out[i]              = mif.rdata[i*LANE_W + LANE_PAR_POS];
    end
  end

  // ---------------------------------------------------------------------
  // Output enable filter
  // ---------------------------------------------------------------------
  // Three stages; the level changes only when the last two agree
  logic [SYNC_STAGES-1:0] oe_sync_ff;
  logic [SYNC_STAGES-1:0] nxt_oe_sync;
  logic                   oe_act_ff;
  logic                   nxt_oe_act;

  always_comb
  begin
    nxt_oe_sync = {oe_sync_ff[SYNC_STAGES-2:0], ~output_enable_n};
    nxt_oe_act  = oe_act_ff;
    if (oe_sync_ff[1] == oe_sync_ff[2])
      nxt_oe_act = oe_sync_ff[2];
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      oe_sync_ff <= '0;
      oe_act_ff  <= RST_OE_ACTIVE;
    end
    else
    begin
      oe_sync_ff <= nxt_oe_sync;
      oe_act_ff  <= nxt_oe_act;
    end
  end

  // Write beat wins over a pending read, avoiding bus contention
  assign dq_oe = rd_valid_ff && oe_act_ff && (op_ff != SBW_OP_WRITE);  // see R5 see R8

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  a_read_ignores_sel: assert property (  // see R1
    @(posedge core_clk) disable iff (!rstn)
    (!advance_or_load && !chip_en_n && write_strobe_n) |=> (op_ff == SBW_OP_READ) && (mif.lane_we == '0)
  ) else $error("read cycle wrote a lane");

  a_nolane_write: assert property (  // see R2
    @(posedge core_clk) disable iff (!rstn)
    (!advance_or_load && !chip_en_n && !write_strobe_n && (&lane_write_select_n))
      |=> (op_ff == SBW_OP_WRITE) && (mif.lane_we == '0) && !dq_oe
  ) else $error("empty write changed a lane");

  a_lane_select_map: assert property (  // see R3
    @(posedge core_clk) disable iff (!rstn)
    (!advance_or_load && !chip_en_n && !write_strobe_n)
      |=> mif.lane_we == ~$past(lane_write_select_n)
  ) else $error("lane enables differ from selects");

  a_all_lanes: assert property (  // see R4
    @(posedge core_clk) disable iff (!rstn)
    (!advance_or_load && !chip_en_n && !write_strobe_n && (lane_write_select_n == '0))
      ##1 (advance_or_load && (lane_write_select_n == '0)) |=> (&mif.lane_we)
  ) else $error("full write missed a lane in burst");

  a_write_tristate: assert property (  // see R5
    @(posedge core_clk) disable iff (!rstn)
    (op_ff == SBW_OP_WRITE) |-> !dq_oe
  ) else $error("data driven during write");

  a_oe_masked: assert property (  // see R8
    @(posedge core_clk) disable iff (!rstn)
    (oe_act_ff && rd_valid_ff) |-> (dq_oe != (op_ff == SBW_OP_WRITE))
  ) else $error("output enable not masked by write");

  a_parity_lane: assert property (  // see R9
    @(posedge core_clk) disable iff (!rstn)
    (op_ff == SBW_OP_WRITE) |-> (mif.wdata[LANE_PAR_POS] == lane_parity_bits_in[0])
      && (mif.wdata[LANE_DATA_W-1:0] == dq_in[LANE_DATA_W-1:0])
  ) else $error("lane zero packing wrong");

  a_write_quiet: assert property (  // see R5
    @(posedge core_clk) disable iff (!rstn)
    (!advance_or_load && !chip_en_n && !write_strobe_n) |=> !dq_oe
  ) else $error("data driven after write command");

  a_burst_lane_sel: assert property (  // see R3
    @(posedge core_clk) disable iff (!rstn)
    (advance_or_load && (op_ff == SBW_OP_WRITE))
      |=> (op_ff == SBW_OP_WRITE) && (mif.lane_we == ~$past(lane_write_select_n))
  ) else $error("burst beat lane enables differ from selects");

endmodule

/* bench/sbw_ctrl_model.sv */
// Memory controller model that drives the SRAM command and data pins.
// Assumes the bench clock; every pin changes on the falling edge only.
`timescale 1ns/1ps
module sbw_ctrl_model #(
  parameter int LANES  = 4,
  parameter int ADDR_W = 6
) (
  input  wire logic                                   core_clk,
  output logic                                        chip_en_n,
  output logic                                        advance_or_load,
  output logic                                        write_strobe_n,
  output logic [LANES-1:0]                            lane_write_select_n,
  output logic [ADDR_W-1:0]                           addr,
  output logic [LANES*sbw_pkg::LANE_DATA_W-1:0]       dq_in,
  output logic [LANES-1:0]                            lane_parity_bits_in
);
  localparam int DW = LANES*sbw_pkg::LANE_DATA_W;

  // ---------------------------------------------------------------------
  // Single-beat, four-beat burst and read-then-write access
  // ---------------------------------------------------------------------
  initial
  begin
    chip_en_n = 1'b1;
    advance_or_load = 1'b0;
    write_strobe_n = 1'b1;
    lane_write_select_n = '1;
    addr = '0;
    dq_in = '0;
    lane_parity_bits_in = '0;
  end

  // Released pins show the inverse, so stale values never look valid
  task automatic access(input logic we_n, input logic [LANES-1:0] sel_n, input logic [ADDR_W-1:0] a,
                        input logic [LANES*sbw_pkg::LANE_DATA_W-1:0] d, input logic [LANES-1:0] p);
    @(negedge core_clk);
    chip_en_n = 1'b0;
    write_strobe_n = we_n;
    lane_write_select_n = sel_n;
    addr = a;
    @(negedge core_clk);
    chip_en_n = 1'b1;
    write_strobe_n = ~we_n;
    lane_write_select_n = ~sel_n;
    addr = ~a;
    dq_in = d;
    lane_parity_bits_in = p;
    @(negedge core_clk);
    dq_in = ~d;
    lane_parity_bits_in = ~p;
  endtask

  // Four-beat write burst; beats drive enables and strobe inactive, as they must be ignored
  task automatic burst(input logic [4*LANES-1:0] sels_n, input logic [ADDR_W-1:0] a,
                       input logic [4*DW-1:0] d, input logic [4*LANES-1:0] p);
    @(negedge core_clk);
    chip_en_n = 1'b0;
    advance_or_load = 1'b0;
    write_strobe_n = 1'b0;
    lane_write_select_n = sels_n[0 +: LANES];
    addr = a;
    for (int k = 1; k < 5; k++)
    begin
      @(negedge core_clk);
      advance_or_load = (k < 4);
      chip_en_n = 1'b1;
      write_strobe_n = 1'b1;
      if (k < 4)
        lane_write_select_n = sels_n[k*LANES +: LANES];
      else
        lane_write_select_n = '1;
      addr = ~a;
      dq_in = d[(k-1)*DW +: DW];
      lane_parity_bits_in = p[(k-1)*LANES +: LANES];
    end
    @(negedge core_clk);
    dq_in = ~dq_in;
    lane_parity_bits_in = ~lane_parity_bits_in;
  endtask

  // Read command directly followed by a write command
  task automatic rd_wr(input logic [LANES-1:0] sel_n, input logic [ADDR_W-1:0] ra, input logic [ADDR_W-1:0] wa,
                       input logic [DW-1:0] d, input logic [LANES-1:0] p);
    @(negedge core_clk);
    chip_en_n = 1'b0;
    advance_or_load = 1'b0;
    write_strobe_n = 1'b1;
    lane_write_select_n = sel_n;
    addr = ra;
    @(negedge core_clk);
    write_strobe_n = 1'b0;
    addr = wa;
    @(negedge core_clk);
    chip_en_n = 1'b1;
    write_strobe_n = 1'b1;
    lane_write_select_n = ~sel_n;
    addr = ~wa;
    dq_in = d;
    lane_parity_bits_in = p;
    @(negedge core_clk);
    dq_in = ~d;
    lane_parity_bits_in = ~p;
  endtask
endmodule

/* bench/sbw_sram_core_bench.sv */
// Self-checking bench for the byte-lane write decode core, four lanes.
// Assumes the controller model drives all command pins.
`timescale 1ns/1ps
module sbw_sram_core_bench;
  import sbw_pkg::*;
  localparam int LN = LANES_WIDE;
  localparam int AW = 6;
  localparam int DW = LN*LANE_DATA_W;
  logic            core_clk;
  logic            rstn;
  logic            output_enable_n;
  logic            chip_en_n;
  logic            advance_or_load;
  logic            write_strobe_n;
  logic [LN-1:0]   lane_write_select_n;
  logic [AW-1:0]   addr;
  logic [DW-1:0]   dq_in;
  logic [LN-1:0]   lane_parity_bits_in;
  logic [DW-1:0]   dq_out;
  logic [LN-1:0]   lane_parity_bits_out;
  logic            dq_oe;
  int              errors;
  int              n_compared;

  sbw_ctrl_model #(.LANES(LN), .ADDR_W(AW)) ctl (.core_clk(core_clk), .chip_en_n(chip_en_n),
    .advance_or_load(advance_or_load), .write_strobe_n(write_strobe_n),
    .lane_write_select_n(lane_write_select_n), .addr(addr), .dq_in(dq_in),
    .lane_parity_bits_in(lane_parity_bits_in));
  sbw_sram_core #(.LANES(LN), .ADDR_W(AW)) dut (.core_clk(core_clk), .rstn(rstn), .chip_en_n(chip_en_n),
    .advance_or_load(advance_or_load), .write_strobe_n(write_strobe_n),
    .lane_write_select_n(lane_write_select_n), .addr(addr), .dq_in(dq_in),
    .lane_parity_bits_in(lane_parity_bits_in), .output_enable_n(output_enable_n), .dq_out(dq_out),
    .lane_parity_bits_out(lane_parity_bits_out), .dq_oe(dq_oe));

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [LN-1:0] s, input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [LN-1:0] p);
    ctl.access(1'b0, s, a, d, p);
    check("dq_oe in write", 64'(dq_oe), 64'h0);
  endtask

  // Selects held low on reads: they must not turn the read into a write
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [LN-1:0] p, input logic oe);
    ctl.access(1'b1, '0, a, ~d, ~p);
    check("dq_oe in read", 64'(dq_oe), 64'(oe));
    if (oe)
    begin
      check("read data", 64'(dq_out), 64'(d));
      check("read parity", 64'(lane_parity_bits_out), 64'(p));
    end
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic sc_read_ignores;
    wr(4'h0, 6'h01, 32'h1122_3344, 4'h5);
    rd(6'h01, 32'h1122_3344, 4'h5, 1'b1);
    rd(6'h01, 32'h1122_3344, 4'h5, 1'b1);
  endtask

  // Every select mix, all-high included, over an all-lane base
  task automatic sc_all_masks;
    logic [DW-1:0] e;
    logic [LN-1:0] ep;
    for (int m = 0; m < 16; m++)
    begin
      wr(4'h0, 6'(m + 8), 32'hA5A5_A5A5, 4'h0);
      wr(4'(m), 6'(m + 8), 32'h5A5A_5A5A, 4'hF);
      for (int i = 0; i < LN; i++)
      begin
        e[8*i +: 8] = m[i] ? 8'hA5 : 8'h5A;
        ep[i] = ~m[i];
      end
      rd(6'(m + 8), e, ep, 1'b1);
    end
  endtask

  // Output enable off gives a dummy read with the pins undriven
  task automatic sc_oe_off;
    output_enable_n = 1'b1;
    repeat (6) @(negedge core_clk);
    rd(6'h01, 32'h1122_3344, 4'h5, 1'b0);
    wr(4'h0, 6'h02, 32'h0F0F_0F0F, 4'hA);
    output_enable_n = 1'b0;
    repeat (6) @(negedge core_clk);
    rd(6'h02, 32'h0F0F_0F0F, 4'hA, 1'b1);
  endtask

  // Wrapping burst: all-lane base, then a different select mix per beat
  task automatic sc_burst;
    ctl.burst(16'h0000, 6'h22, {4{32'hC3C3_C3C3}}, 16'h0000);
    ctl.burst(16'h0F5E, 6'h22, {4{32'h3C3C_3C3C}}, 16'hFFFF);
    rd(6'h22, 32'hC3C3_C33C, 4'h1, 1'b1);
    rd(6'h23, 32'h3CC3_3CC3, 4'hA, 1'b1);
    rd(6'h20, 32'hC3C3_C3C3, 4'h0, 1'b1);
    rd(6'h21, 32'h3C3C_3C3C, 4'hF, 1'b1);
  endtask

  // Pending read meets a write data beat: pins must stay released
  task automatic sc_read_write;
    fork
      ctl.rd_wr(4'h0, 6'h01, 6'h30, 32'h7788_99AA, 4'h6);
      begin
        repeat (3) @(negedge core_clk);
        check("dq_oe write after read", 64'(dq_oe), 64'h0);
        check("read before write", 64'(dq_out), 64'h1122_3344);
      end
    join
    rd(6'h30, 32'h7788_99AA, 4'h6, 1'b1);
  endtask

  // ---------------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ---------------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial
  begin
    errors = 0;
    n_compared = 0;
    rstn = 1'b0;
    output_enable_n = 1'b0;
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    repeat (6) @(negedge core_clk);
    sc_read_ignores();
    sc_all_masks();
    sc_oe_off();
    sc_burst();
    sc_read_write();
    give_verdict();
  end

  initial
  begin
    repeat (5000) @(posedge core_clk);
    errors++;
    give_verdict();
  end
endmodule
